// [logic/sdll_host.sv]
// Host controller that frames words onto a serial-input converter and drives its load strobe.
//
// Contract
// - 16-bit words travel most significant bit first.
// - Host keeps serial clock at most 25 MHz.
// - Host holds load strobe high while shifting in asynchronous load mode; synchronous mode holds it low.
// - First load after power-up sends sixteen bits.
// - Short host words padded with low zeros.
`timescale 1ns/1ps
module sdll_host
  import sdll_pkg::*;
#(
  parameter int WORD_W   = 16,
  parameter int HALF_CYC = SDLL_MIN_HALF_CYC
) (
  // Clock and reset.
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  // Word request from the user side.
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic [WORD_W-1:0] req_data,
  input  wire logic              req_async_load,
  // Transfer status.
  output logic                   busy,
  output logic                   done,
  // Converter pins.
  output logic                   sclk,
  output logic                   sdata,
  output logic                   select_n,
  output logic                   converter_load_n
);

  // Refuse word widths and dividers the sequencer cannot serve.
  initial begin
    if (WORD_W < 1 || WORD_W > SDLL_WORD_BITS) begin
      $error("sdll_host: WORD_W must lie between 1 and the link word width");
    end
    if (HALF_CYC < SDLL_MIN_HALF_CYC) begin
      $error("sdll_host: HALF_CYC makes the serial clock too fast");
    end
  end

  localparam logic [SDLL_BIT_CNT_W-1:0] LAST_BIT = SDLL_BIT_CNT_W'(SDLL_WORD_BITS - 1);
  localparam int                        PAD_BITS = SDLL_WORD_BITS - WORD_W;

  sdll_state_type              state;
  logic [SDLL_WORD_BITS-1:0]   shift_word;
  logic [SDLL_WORD_BITS-1:0]   padded;
  logic [SDLL_BIT_CNT_W-1:0]   bit_count;
  logic                        async_mode;
  logic                        tick;
  logic                        take;

  // Serial clock pacing; the divider keeps the link at or below its top rate.
  sdll_tick #(
    .HALF_CYC (HALF_CYC)
  ) u_tick (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .run     (state != SDLL_IDLE),
    .tick    (tick)
  );

  // Short words are left-justified with zeros filling the low end.
  assign padded = SDLL_WORD_BITS'(req_data) << PAD_BITS;

  // A request is accepted only while no frame is in progress.
  assign req_ready = (state == SDLL_IDLE);
  assign take      = req_valid && req_ready;
  assign busy      = (state != SDLL_IDLE);

  // Transfer sequencer.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state <= SDLL_IDLE;
    end else begin
      case (state)
        SDLL_IDLE: begin
          if (take) begin
            state <= SDLL_LOWPH;
          end
        end
        SDLL_LOWPH: begin
          if (tick) begin
            state <= SDLL_HIGHPH;
          end
        end
        SDLL_HIGHPH: begin
          if (tick) begin
            // Every frame carries the full word, so no stale bits reach the converter.
            if (bit_count == LAST_BIT) begin
              state <= SDLL_DESEL;
            end else begin
              state <= SDLL_LOWPH;
            end
          end
        end
        SDLL_DESEL: begin
          if (tick) begin
            state <= async_mode ? SDLL_LOAD : SDLL_FINISH;
          end
        end
        SDLL_LOAD: begin
          if (tick && !converter_load_n) begin
            state <= SDLL_FINISH;
          end
        end
        SDLL_FINISH: begin
          if (tick) begin
            state <= SDLL_IDLE;
          end
        end
        default: begin
          state <= SDLL_IDLE;
        end
      endcase
    end
  end

  // Load mode is captured with each word.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      async_mode <= 1'b0;
    end else if (take) begin
      async_mode <= req_async_load;
    end
  end

  // Word shifter; the most significant bit leaves first.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      shift_word <= '0;
    end else if (take) begin
      shift_word <= padded;
    end else if (state == SDLL_HIGHPH && tick && bit_count != LAST_BIT) begin
      shift_word <= {shift_word[SDLL_WORD_BITS-2:0], 1'b0};
    end
  end

  // Data pin changes only while the serial clock is low, ahead of each rising edge.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sdata <= 1'b0;
    end else if (take) begin
      sdata <= padded[SDLL_WORD_BITS-1];
    end else if (state == SDLL_HIGHPH && tick && bit_count != LAST_BIT) begin
      sdata <= shift_word[SDLL_WORD_BITS-2];
    end
  end

  // Bits sent so far in this frame.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      bit_count <= '0;
    end else if (take) begin
      bit_count <= '0;
    end else if (state == SDLL_HIGHPH && tick) begin
      bit_count <= bit_count + SDLL_BIT_CNT_W'(1);
    end
  end

  // Serial clock rises once per bit and idles low outside frames.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sclk <= SDLL_SCLK_IDLE;
    end else if (state == SDLL_LOWPH && tick) begin
      sclk <= 1'b1;
    end else if (state == SDLL_HIGHPH && tick) begin
      sclk <= 1'b0;
    end
  end

  // Select frames exactly sixteen rising edges; its rise ends the frame.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      select_n <= SDLL_SELECT_IDLE;
    end else if (take) begin
      select_n <= 1'b0;
    end else if (state == SDLL_DESEL && tick) begin
      select_n <= 1'b1;
    end
  end

  // Load strobe: held low in synchronous mode, pulsed after select rises otherwise.
  // A strobe that falls while select is still high would copy a stale input register,
  // so a switch to synchronous mode lowers it only once select is already low.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      converter_load_n <= SDLL_LOAD_IDLE;
    end else if (take) begin
      converter_load_n <= converter_load_n | req_async_load;
    end else if (state == SDLL_LOWPH && !async_mode) begin
      converter_load_n <= 1'b0;
    end else if (state == SDLL_LOAD && tick) begin
      converter_load_n <= !converter_load_n;
    end
  end

  // Completion pulse once the frame and any load pulse are over.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      done <= 1'b0;
    end else begin
      done <= (state == SDLL_FINISH) && tick;
    end
  end

endmodule

// [common/sdll_pkg.sv]
// Shared constants and types for the serial converter load host controller.
package sdll_pkg;

  // Word format on the serial link.
  localparam int SDLL_WORD_BITS = 16;
  localparam int SDLL_BIT_CNT_W = 5;

  // Reference clock period and the fastest serial clock the converter accepts.
  localparam int SDLL_REF_PERIOD_NS   = 100;
  localparam int SDLL_SCLK_MAX_MHZ    = 25;
  localparam int SDLL_SCLK_MIN_PER_NS = 1000 / SDLL_SCLK_MAX_MHZ;

  // Least reference cycles per half serial clock period, rounded up, never below one.
  localparam int SDLL_MIN_HALF_RAW = (SDLL_SCLK_MIN_PER_NS + 2 * SDLL_REF_PERIOD_NS - 1) / (2 * SDLL_REF_PERIOD_NS);
  localparam int SDLL_MIN_HALF_CYC = (SDLL_MIN_HALF_RAW < 1) ? 1 : SDLL_MIN_HALF_RAW;

  // Divider counter width.
  localparam int SDLL_DIV_W = 16;

  // Pin levels after reset.
  localparam logic SDLL_SCLK_IDLE   = 1'b0;
  localparam logic SDLL_SELECT_IDLE = 1'b1;
  localparam logic SDLL_LOAD_IDLE   = 1'b1;

  // Transfer sequencer states.
  typedef enum logic [2:0] {
    SDLL_IDLE   = 3'b000,
    SDLL_LOWPH  = 3'b001,
    SDLL_HIGHPH = 3'b010,
    SDLL_DESEL  = 3'b011,
    SDLL_LOAD   = 3'b100,
    SDLL_FINISH = 3'b101
  } sdll_state_type;

endpackage

// [logic/sdll_tick.sv]
// Half-period tick generator that paces the serial clock made by the host.
`timescale 1ns/1ps
module sdll_tick
  import sdll_pkg::*;
#(
  parameter int HALF_CYC = 1
) (
  // Clock and reset.
  input  wire logic ref_clk,
  input  wire logic resetn,
  // Control and tick.
  input  wire logic run,
  output logic      tick
);

  // Refuse a divider that the counter cannot hold or that would be zero.
  initial begin
    if (HALF_CYC < 1 || HALF_CYC >= (1 << SDLL_DIV_W)) begin
      $error("sdll_tick: HALF_CYC out of range");
    end
  end

  localparam logic [SDLL_DIV_W-1:0] LAST = SDLL_DIV_W'(HALF_CYC - 1);

  logic [SDLL_DIV_W-1:0] count;

  // Counts reference cycles while running and restarts whenever stopped.
  always_ff @(posedge ref_clk) begin
    if (!resetn || !run) begin
      count <= '0;
    end else if (count == LAST) begin
      count <= '0;
    end else begin
      count <= count + SDLL_DIV_W'(1);
    end
  end

  // One tick per half serial period.
  assign tick = run && (count == LAST);

endmodule

// [bench/sdll_host_checker.sv]
// Checker of the host pin timing on the serial converter link.
`timescale 1ns/1ps
module sdll_host_checker #(
  parameter int HALF_CYC = 1
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // Request side.
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_async_load,
  // Converter pins.
  input wire logic sclk,
  input wire logic sdata,
  input wire logic select_n,
  input wire logic converter_load_n
);
  logic       async_mode;
  logic [4:0] edges;
  logic [7:0] high_len;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Remembers the load mode of the word in flight.
  always_ff @(posedge ref_clk) begin
    if (!resetn) async_mode <= 1'b0;
    else if (req_valid && req_ready) async_mode <= req_async_load;
  end
  // Counts serial clock rises within one frame.
  always_ff @(posedge ref_clk) begin
    if (!resetn || select_n) edges <= 5'h00;
    else if ($rose(sclk)) edges <= edges + 5'h01;
  end
  // Measures how long the serial clock stays high.
  always_ff @(posedge ref_clk) begin
    if (!resetn || !sclk) high_len <= 8'h00;
    else high_len <= high_len + 8'h01;
  end
  a_frame_bit_count: assert property ($rose(select_n) |-> edges == 5'h10)
    else $error("frame closed without sixteen clock rises");
  a_data_held_high: assert property (!select_n && sclk |-> $stable(sdata))
    else $error("serial data moved while clock high");
  a_clock_half_len: assert property ($fell(sclk) |-> high_len == 8'(HALF_CYC))
    else $error("serial clock high phase has wrong length");
  a_load_high_shift: assert property (async_mode && !select_n |-> converter_load_n)
    else $error("load strobe low while shifting");
  a_load_after_select: assert property (async_mode && $rose(select_n) |-> ##1 !converter_load_n ##HALF_CYC converter_load_n)
    else $error("load strobe pulse misplaced");
  a_load_fall_framed: assert property ($fell(converter_load_n) |-> async_mode == select_n)
    else $error("load strobe fell outside its allowed window");
endmodule

bind sdll_host sdll_host_checker #(.HALF_CYC(HALF_CYC)) sdll_host_checker_inst (
  .ref_clk(ref_clk), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready),
  .req_async_load(req_async_load), .sclk(sclk), .sdata(sdata), .select_n(select_n),
  .converter_load_n(converter_load_n));

// [bench/sdll_conv_model.sv]
// Behavioural model of the serial-input converter on the far side.
`timescale 1ns/1ps
module sdll_conv_model (
  // Serial pins from the host.
  input  wire logic        sclk,
  input  wire logic        sdata,
  input  wire logic        select_n,
  input  wire logic        converter_load_n,
  // Converter state and switch controls.
  output logic [15:0]      conv_reg,
  output logic [15:0]      shift_reg,
  output logic [14:0]      segment_switches,
  output logic [11:0]      ladder_switches
);
  // Power-up clears the converter register but leaves the shift register unknown.
  initial conv_reg = 16'h0000;
  // Shifts MSB first while selected, keeping the last sixteen bits.
  always @(posedge sclk) if (!select_n) shift_reg <= {shift_reg[14:0], sdata};
  // Select rise with the strobe low, or a strobe fall with select high, loads the register.
  always @(posedge select_n or negedge converter_load_n) begin
    if (select_n && !converter_load_n) conv_reg <= shift_reg;
  end
  // Thermometer segments from the top nibble, ladder from the rest.
  always_comb begin
    for (int k = 0; k < 15; k++) segment_switches[k] = (conv_reg[15:12] > k);
    ladder_switches = conv_reg[11:0];
  end
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the serial converter host controller.
`timescale 1ns/1ps
module tb_top;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        req_valid = 1'b0;
  logic        req_async_load = 1'b0;
  logic [15:0] req_data = 16'h0000;
  logic        req_ready, busy, done, sclk, sdata, select_n, converter_load_n;
  logic [15:0] conv_reg, shift_reg;
  logic [14:0] segs;
  logic [11:0] ladder;
  int          fails = 0;
  int          tests_run = 0;
  sdll_host #(.WORD_W(16), .HALF_CYC(1)) sdll_host_inst (
    .ref_clk(ref_clk), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready),
    .req_data(req_data), .req_async_load(req_async_load), .busy(busy), .done(done),
    .sclk(sclk), .sdata(sdata), .select_n(select_n), .converter_load_n(converter_load_n));
  sdll_conv_model sdll_conv_model_inst (
    .sclk(sclk), .sdata(sdata), .select_n(select_n), .converter_load_n(converter_load_n),
    .conv_reg(conv_reg), .shift_reg(shift_reg), .segment_switches(segs), .ladder_switches(ladder));
  // Reference clock.
  always #50 ref_clk = ~ref_clk;
  // Compares one observed value with its expectation.
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Hands one word to the host and waits for the end of its frame.
  task automatic send(input logic [15:0] d, input logic a);
    int n;
    @(posedge ref_clk);
    req_data <= d;
    req_async_load <= a;
    req_valid <= 1'b1;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    for (n = 0; n < 200 && done !== 1'b1; n++) @(posedge ref_clk);
    if (n == 200) begin
      fails++;
      test_done();
    end
    check("frame_len", 16'(n), a ? 16'h0025 : 16'h0023);
    check("shift", shift_reg, d);
    check("idle", {13'h0000, busy, req_ready, select_n}, 16'h0003);
  endtask
  // Releases reset and looks at the power-up converter value.
  task automatic t_reset();
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    check("conv_reset", conv_reg, 16'h0000);
    check("pins_reset", {12'h000, sclk, select_n, converter_load_n, busy}, 16'h0006);
  endtask
  // Cuts a strobe-mode frame by reset, then sends a full word.
  task automatic t_abort();
    @(posedge ref_clk);
    req_data <= 16'h1234;
    req_async_load <= 1'b1;
    req_valid <= 1'b1;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    check("conv_abort", conv_reg, 16'h7fff);
    check("pins_abort", {12'h000, sclk, select_n, converter_load_n, busy}, 16'h0006);
    send(16'h0f0f, 1'b0);
    check("conv_after", conv_reg, 16'h0f0f);
  endtask
  // Loads one word by the strobe pulse and one by select alone.
  task automatic t_modes();
    send(16'h3c5a, 1'b1);
    check("conv_async", conv_reg, 16'h3c5a);
    check("load_idle", {15'h0000, converter_load_n}, 16'h0001);
    send(16'ha5c3, 1'b0);
    check("conv_sync", conv_reg, 16'ha5c3);
  endtask
  // Walks the boundary codes through both load modes.
  task automatic t_codes();
    logic [15:0] codes [5] = '{16'hffff, 16'h8000, 16'h0001, 16'h0000, 16'h7fff};
    for (int i = 0; i < 5; i++) begin
      send(codes[i], i[0]);
      check("conv_code", conv_reg, codes[i]);
      check("ladder", {4'h0, ladder}, {4'h0, codes[i][11:0]});
      check("segments", {1'b0, segs}, {1'b0, ~(15'h7fff << codes[i][15:12])});
    end
  endtask
  // Main sequence.
  initial begin
    t_reset();
    t_modes();
    t_codes();
    t_abort();
    test_done();
  end
endmodule
